// ===== hdl/npf_phase_freq_control.sv
// Phase and frequency control section: accumulators, phase adder, timer
//
// Overview of operation
// - Each clock the argument buffer is ready, the phase step is added into the 32-bit phase accumulator.
// - The addition wraps modulo two to the thirty-second; low 32 bits kept.
// - The inverted accumulator overflow drives the phase carry-out output.
// - Phase register adds to the top 16 accumulator bits, forming the argument.
// - Chip select and write strobe low store the bus word per select code.
// - High and low input halves join into one 32-bit load word.
// - Center load enable is registered, then reloads center frequency while low.
// - Source select high: registered phase enable low copies phase input.
// - Source select low: quadrature code gives top phase bits, rest zero.
// - The phase increment is the modular sum of center and offset.
// - A step of one advances the phase by one count per clock.
// - Offset disable low zeroes the offset term but keeps its contents.
// - Accumulator initialize low zeroes feedback; next clock loads the step.
// - Range select limits final phase to a half or a full circle.
// - Timer increment loads while its enable is low; timer adds it each clock.
// - Timer accumulator carry-out is the only timer output pulse.
// - Timer initialize zeroes timer feedback, stopping pulses and resetting it.
// - The frequency step is two's complement; its sign picks the sideband.
`timescale 1ns/1ps
module npf_phase_freq_control #(
	parameter int PHASE_W = npf_pkg::PHASE_W,
	parameter int HALF_W  = npf_pkg::HALF_W
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	// Host write port
	input  wire logic [15:0] controlWordBus,
	input  wire logic [1:0]  writeSelectCode,
	input  wire logic        chipSelectN,
	input  wire logic        writeStrobeN,
	// Register load enables, active low
	input  wire logic        centerFreqLoadN,
	input  wire logic        offsetFreqLoadN,
	input  wire logic        phaseLoadN,
	input  wire logic        timerIncrLoadN,
	// Mode and control lines
	input  wire logic        phaseSourceSelect,
	input  wire logic [1:0]  quadraturePhaseCode,
	input  wire logic        offsetFreqDisableN,
	input  wire logic        accumInitN,
	input  wire logic        phaseRangeSelect,
	input  wire logic        timerAccumInit,
	// Argument stream toward the sine/cosine stage
	output logic [31:0]      sinCosArg,
	output logic             sinCosCarry,
	output logic             argValid,
	input  wire logic        argReady,
	// Carry outputs
	output logic             phaseCarryOut,
	output logic             timerCarryOut
);
	generate
		if (PHASE_W != 2 * HALF_W || HALF_W != npf_pkg::CWORD_W) begin : gChk
			$error("npf_phase_freq_control: unsupported widths");
		end
	endgenerate

	// Reset release synchroniser
	logic rstMeta_reg;
	logic rstSync_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	wire rstN = rstSync_reg;

	// Host write decode
	logic [HALF_W-1:0] freqLow_reg;
	logic [HALF_W-1:0] freqHigh_reg;
	logic [HALF_W-1:0] phaseInput_reg;

	wire writeActive = !chipSelectN && !writeStrobeN;
	wire wrFreqLow   = writeActive
		&& (writeSelectCode == npf_pkg::SEL_FREQ_LOW);
	wire wrFreqHigh  = writeActive
		&& (writeSelectCode == npf_pkg::SEL_FREQ_HIGH);
	wire wrPhaseIn   = writeActive
		&& (writeSelectCode == npf_pkg::SEL_PHASE_IN);
	// Reserved code stores nothing

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			freqLow_reg    <= npf_pkg::HALF_RESET;
			freqHigh_reg   <= npf_pkg::HALF_RESET;
			phaseInput_reg <= npf_pkg::HALF_RESET;
		end else begin
			if (wrFreqLow)
				freqLow_reg <= controlWordBus;
			if (wrFreqHigh)
				freqHigh_reg <= controlWordBus;
			if (wrPhaseIn)
				phaseInput_reg <= controlWordBus;
		end
	end

	wire [PHASE_W-1:0] loadWord = {freqHigh_reg, freqLow_reg};

	// Registered load enables, one edge behind the pins
	npf_pkg::npf_loads_t loadsPin;
	npf_pkg::npf_loads_t loads_reg;

	assign loadsPin = '{centerLoadN: centerFreqLoadN,
		offsetLoadN: offsetFreqLoadN,
		phaseLoadN:  phaseLoadN,
		timerLoadN:  timerIncrLoadN};

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			loads_reg <= '{default: npf_pkg::LOAD_N_IDLE};
		else
			loads_reg <= loadsPin;
	end

	// Frequency, phase and timer increment registers
	logic [PHASE_W-1:0] centerFreq_reg;
	logic [PHASE_W-1:0] offsetFreq_reg;
	logic [PHASE_W-1:0] timerIncr_reg;
	logic [HALF_W-1:0]  phaseReg_reg;

	// Quadrature code 00,01,10,11 -> 0,90,270,180 degrees
	wire [1:0] qpskTop = {quadraturePhaseCode[1],
		quadraturePhaseCode[1] ^ quadraturePhaseCode[0]};
	wire [HALF_W-1:0] qpskPhase = {qpskTop,
		npf_pkg::QPSK_LOW_ZERO[npf_pkg::QPSK_LO_W-1:0]};
	wire [HALF_W-1:0] phaseSource = phaseSourceSelect
		? phaseInput_reg : qpskPhase;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			centerFreq_reg <= npf_pkg::FREQ_RESET;
			offsetFreq_reg <= npf_pkg::FREQ_RESET;
			timerIncr_reg  <= npf_pkg::FREQ_RESET;
			phaseReg_reg   <= npf_pkg::HALF_RESET;
		end else begin
			if (!loads_reg.centerLoadN)
				centerFreq_reg <= loadWord;
			if (!loads_reg.offsetLoadN)
				offsetFreq_reg <= loadWord;
			if (!loads_reg.phaseLoadN)
				phaseReg_reg <= phaseSource;
			// Timer increment takes the pin enable directly
			if (!timerIncrLoadN)
				timerIncr_reg <= loadWord;
		end
	end

	// Phase step: offset term gated, register contents kept intact
	wire [PHASE_W-1:0] offsetTerm = offsetFreqDisableN
		? offsetFreq_reg : npf_pkg::FREQ_RESET;
	// Two's complement sum; a negative step rotates the other way
	wire [PHASE_W-1:0] phaseStep = centerFreq_reg + offsetTerm;

	// Phase accumulator
	logic [PHASE_W-1:0] phaseAcc_reg;
	logic               phaseCarry_reg;

	wire [PHASE_W-1:0] phaseFeedback = accumInitN
		? phaseAcc_reg : npf_pkg::ACC_RESET;
	wire [PHASE_W:0]   phaseSum = {1'b0, phaseFeedback}
		+ {1'b0, phaseStep};

	// The accumulator advances only while the buffer can take the argument,
	// so a stalled receiver skips no phase value; hold ready high to free-run
	wire bufInReady;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			phaseAcc_reg   <= npf_pkg::ACC_RESET;
			phaseCarry_reg <= 1'b1;
		end else if (bufInReady) begin
			phaseAcc_reg   <= phaseSum[PHASE_W-1:0];
			phaseCarry_reg <= ~phaseSum[PHASE_W];
		end
	end

	assign phaseCarryOut = phaseCarry_reg;

	// Phase adder on the top half
	wire [HALF_W-1:0] topSum = phaseAcc_reg[PHASE_W-1:HALF_W]
		+ phaseReg_reg;
	wire [HALF_W-1:0] rangeMask = phaseRangeSelect
		? npf_pkg::FULL_CIRCLE_MASK
		: npf_pkg::HALF_CIRCLE_MASK;
	wire [PHASE_W-1:0] argWord = {topSum & rangeMask,
		phaseAcc_reg[HALF_W-1:0]};

	npf_pkg::npf_arg_t bufIn;
	npf_pkg::npf_arg_t bufOut;

	assign bufIn = '{arg: argWord, phaseCarry: phaseCarry_reg};

	npf_buf2 #(
		.WIDTH ($bits(npf_pkg::npf_arg_t))
	) uArgBuf (
		.clk      (clk),
		.rstN     (rstN),
		.inData   (bufIn),
		.inValid  (rstN),
		.inReady  (bufInReady),
		.outData  (bufOut),
		.outValid (argValid),
		.outReady (argReady)
	);

	assign sinCosArg   = bufOut.arg;
	assign sinCosCarry = bufOut.phaseCarry;

	// Time accumulator; free running, independent of the argument stream
	logic [PHASE_W-1:0] timerAcc_reg;
	logic               timerCarry_reg;

	wire [PHASE_W-1:0] timerFeedback = timerAccumInit
		? npf_pkg::ACC_RESET : timerAcc_reg;
	wire [PHASE_W:0]   timerSum = {1'b0, timerFeedback}
		+ {1'b0, timerIncr_reg};

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			timerAcc_reg   <= npf_pkg::ACC_RESET;
			timerCarry_reg <= 1'b0;
		end else begin
			timerAcc_reg   <= timerSum[PHASE_W-1:0];
			// Held quiet during initialize so no stray pulse escapes
			timerCarry_reg <= timerSum[PHASE_W]
				& ~timerAccumInit;
		end
	end

	assign timerCarryOut = timerCarry_reg;
endmodule : npf_phase_freq_control

// ===== hdl/npf_pkg.sv
// Shared constants and types of the phase and frequency control section
package npf_pkg;
	localparam int PHASE_W   = 32;
	localparam int HALF_W    = 16;
	localparam int CWORD_W   = 16;
	localparam int SEL_W     = 2;
	localparam int QPSK_LO_W = 14;

	// Write select codes of the control word bus
	localparam logic [1:0] SEL_FREQ_LOW   = 2'h0;
	localparam logic [1:0] SEL_FREQ_HIGH  = 2'h1;
	localparam logic [1:0] SEL_PHASE_IN   = 2'h2;
	localparam logic [1:0] SEL_RESERVED   = 2'h3;

	// Reset values, quadrature low bits and range masks
	localparam logic [31:0] ACC_RESET      = 32'h0000_0000;
	localparam logic [31:0] FREQ_RESET     = 32'h0000_0000;
	localparam logic [15:0] HALF_RESET     = 16'h0000;
	localparam logic        LOAD_N_IDLE    = 1'h1;
	localparam logic [15:0] QPSK_LOW_ZERO  = 16'h0000;
	localparam logic [15:0] HALF_CIRCLE_MASK = 16'h7FFF;
	localparam logic [15:0] FULL_CIRCLE_MASK = 16'hFFFF;

	// One word of the argument stream
	typedef struct packed {
		logic [31:0] arg;
		logic        phaseCarry;
	} npf_arg_t;

	// Loose control inputs grouped together
	typedef struct packed {
		logic centerLoadN;
		logic offsetLoadN;
		logic phaseLoadN;
		logic timerLoadN;
	} npf_loads_t;
endpackage : npf_pkg

// ===== hdl/npf_buf2.sv
// Two-entry buffer with valid/ready on both sides and registered storage
`timescale 1ns/1ps
module npf_buf2 #(
	parameter int WIDTH = 33
) (
	input  wire logic             clk,
	input  wire logic             rstN,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	generate
		if (WIDTH < 1) begin : gChk
			$error("npf_buf2: WIDTH must be at least 1");
		end
	endgenerate

	logic [WIDTH-1:0] entry0_reg;
	logic [WIDTH-1:0] entry1_reg;
	logic             wrPtr_reg;
	logic             rdPtr_reg;
	logic [1:0]       count_reg;
	logic [1:0]       count_next;
	wire              push = inValid & inReady;
	wire              pop  = outValid & outReady;

	assign inReady    = (count_reg != 2'h2);
	assign outValid   = (count_reg != 2'h0);
	assign outData    = rdPtr_reg ? entry1_reg : entry0_reg;
	assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			entry0_reg <= '0;
			entry1_reg <= '0;
			wrPtr_reg  <= 1'b0;
			rdPtr_reg  <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push && !wrPtr_reg)
				entry0_reg <= inData;
			if (push && wrPtr_reg)
				entry1_reg <= inData;
			if (push)
				wrPtr_reg <= ~wrPtr_reg;
			if (pop)
				rdPtr_reg <= ~rdPtr_reg;
			count_reg <= count_next;
		end
	end
endmodule : npf_buf2

// ===== bench/npf_sva.sv
// Port checker of the phase and frequency control section
`timescale 1ns/1ps
module npf_sva (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [31:0] sinCosArg,
	input wire logic        argValid,
	input wire logic        argReady,
	input wire logic        phaseCarryOut,
	input wire logic        timerCarryOut,
	input wire logic        timerAccumInit,
	input wire logic        phaseRangeSelect,
	input wire logic        accumInitN,
	input wire logic        centerFreqLoadN,
	input wire logic        offsetFreqLoadN,
	input wire logic        phaseLoadN,
	input wire logic        offsetFreqDisableN
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire noLoad = centerFreqLoadN && offsetFreqLoadN && phaseLoadN;
	rst_quiet_a: assert property ($rose(resetn) |->
		phaseCarryOut && !argValid ##1 !argValid) else $error("bad reset");
	valid_hold_a: assert property (argValid && !argReady |=> argValid)
		else $error("valid dropped");
	arg_hold_a: assert property (argValid && !argReady |=>
		$stable(sinCosArg)) else $error("arg changed in stall");
	stream_live_a: assert property ((resetn && argReady)[*8] |-> argValid)
		else $error("stream stalled");
	half_circle_a: assert property ((!phaseRangeSelect && argReady)[*4]
		|-> !sinCosArg[31]) else $error("arg above half circle");
	timer_init_a: assert property (timerAccumInit |=> !timerCarryOut)
		else $error("timer pulse in init");
	timer_fell_a: assert property ($fell(timerAccumInit) |-> !timerCarryOut)
		else $error("timer pulse at init end");
	init_freeze_a: assert property ((!accumInitN && argReady && noLoad
		&& $stable(offsetFreqDisableN) && $stable(phaseRangeSelect))[*6]
		|-> $stable(sinCosArg)) else $error("arg moved in init");
	cover property (argValid && !argReady);
	cover property (!phaseCarryOut);
	cover property (timerCarryOut);
endmodule : npf_sva
bind npf_phase_freq_control npf_sva i_npf_sva (.clk, .resetn, .sinCosArg,
	.argValid, .argReady, .phaseCarryOut, .timerCarryOut, .timerAccumInit,
	.phaseRangeSelect, .accumInitN, .centerFreqLoadN, .offsetFreqLoadN,
	.phaseLoadN, .offsetFreqDisableN);

// ===== bench/npf_host.sv
// Host processor model on the control word write port
`timescale 1ns/1ps
module npf_host (
	input  wire logic  clk,
	output logic [15:0] controlWordBus,
	output logic [1:0]  writeSelectCode,
	output logic        chipSelectN,
	output logic        writeStrobeN
);
	initial begin
		controlWordBus = 16'h0000;
		writeSelectCode = 2'h3;
		chipSelectN = 1'h1;
		writeStrobeN = 1'h1;
	end
	// One edge with select and strobe low, then the idle bus shows ~data
	task automatic wr(input logic [1:0] code, input logic [15:0] data);
		@(posedge clk);
		controlWordBus <= data;
		writeSelectCode <= code;
		chipSelectN <= 1'h0;
		writeStrobeN <= 1'h0;
		@(posedge clk);
		chipSelectN <= 1'h1;
		writeStrobeN <= 1'h1;
		controlWordBus <= ~data;
	endtask : wr
	task automatic load32(input logic [31:0] v);
		wr(npf_pkg::SEL_FREQ_LOW, v[15:0]);
		wr(npf_pkg::SEL_FREQ_HIGH, v[31:16]);
	endtask : load32
endmodule : npf_host

// ===== bench/tb_top.sv
// Self-checking bench of the phase and frequency control section
`timescale 1ns/1ps
module tb_top;
	logic                clk = 1'h0;
	logic                resetn = 1'h0;
	logic         [15:0] cBus;
	logic         [1:0]  cSel;
	logic                csN;
	logic                wrN;
	npf_pkg::npf_loads_t ld = 4'hF;
	logic                srcSel = 1'h1;
	logic         [1:0]  quad = 2'h0;
	logic                offEnN = 1'h1;
	logic                initN = 1'h1;
	logic                rangeSel = 1'h1;
	logic                tInit = 1'h1;
	logic                argReady = 1'h1;
	logic         [31:0] arg;
	logic                argValid;
	logic                pCarry;
	logic                tCarry;
	logic                aCarry;
	int                  mismatches = 0;
	int                  checksDone = 0;
	always #5 clk = ~clk;
	npf_host i_npf_host (.clk, .controlWordBus(cBus), .writeSelectCode(cSel),
		.chipSelectN(csN), .writeStrobeN(wrN));
	npf_phase_freq_control i_npf_phase_freq_control (.clk, .resetn,
		.controlWordBus(cBus), .writeSelectCode(cSel), .chipSelectN(csN),
		.writeStrobeN(wrN), .centerFreqLoadN(ld.centerLoadN),
		.offsetFreqLoadN(ld.offsetLoadN), .phaseLoadN(ld.phaseLoadN),
		.timerIncrLoadN(ld.timerLoadN), .phaseSourceSelect(srcSel),
		.quadraturePhaseCode(quad), .offsetFreqDisableN(offEnN),
		.accumInitN(initN), .phaseRangeSelect(rangeSel),
		.timerAccumInit(tInit), .sinCosArg(arg), .sinCosCarry(aCarry),
		.argValid,
		.argReady, .phaseCarryOut(pCarry), .timerCarryOut(tCarry));
	task automatic chk(input logic [31:0] got, exp);
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_n
	// Registered enables need two edges before the target register moves
	task automatic pulse(input npf_pkg::npf_loads_t v);
		@(posedge clk) ld <= v;
		@(posedge clk) ld <= 4'hF;
		wait_n(6);
	endtask : pulse
	task automatic step(input int n, input logic [31:0] exp);
		logic [31:0] a;
		wait_n(n);
		a = arg;
		wait_n(1);
		chk(arg - a, exp);
	endtask : step
	task automatic cnt(input logic [31:0] expP, expT);
		logic [31:0] p;
		logic [31:0] t;
		logic [31:0] c;
		p = 32'h0;
		t = 32'h0;
		c = 32'h0;
		repeat (8) begin
			wait_n(1);
			p += {31'h0, ~pCarry};
			t += {31'h0, tCarry};
			c += {31'h0, ~aCarry};
		end
		chk(p, expP);
		chk(c, expP);
		chk(t, expT);
	endtask : cnt
	task automatic t_freq;
		i_npf_host.load32(32'h0000_0001);
		pulse(4'h7);
		step(6, 32'h0000_0001);
		i_npf_host.wr(npf_pkg::SEL_RESERVED, 16'hFFFF);
		pulse(4'h7);
		step(6, 32'h0000_0001);
		i_npf_host.load32(32'h0000_0002);
		pulse(4'hB);
		step(6, 32'h0000_0003);
		@(posedge clk) offEnN <= 1'h0;
		step(6, 32'h0000_0001);
		@(posedge clk) offEnN <= 1'h1;
		step(6, 32'h0000_0003);
	endtask : t_freq
	task automatic t_wrap;
		@(posedge clk) offEnN <= 1'h0;
		i_npf_host.load32(32'h8000_0000);
		pulse(4'h6);
		cnt(4, 0);
		@(posedge clk) tInit <= 1'h0;
		cnt(4, 4);
		i_npf_host.load32(32'hFFFF_FFFF);
		pulse(4'h7);
		step(6, 32'hFFFF_FFFF);
	endtask : t_wrap
	task automatic t_phase;
		logic [15:0] qTop [4] = '{16'h0000, 16'h4000, 16'hC000, 16'h8000};
		i_npf_host.load32(32'h0000_0000);
		pulse(4'h7);
		@(posedge clk) initN <= 1'h0;
		repeat (8) @(posedge clk);
		initN <= 1'h1;
		i_npf_host.wr(npf_pkg::SEL_PHASE_IN, 16'h1234);
		pulse(4'hD);
		chk(arg, 32'h1234_0000);
		@(posedge clk) srcSel <= 1'h0;
		ld <= 4'hD;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) quad <= i[1:0];
			wait_n(6);
			chk(arg, {qTop[i], 16'h0000});
		end
		@(posedge clk) rangeSel <= 1'h0;
		wait_n(6);
		chk(arg, 32'h0000_0000);
		@(posedge clk) rangeSel <= 1'h1;
		srcSel <= 1'h1;
		ld <= 4'hF;
	endtask : t_phase
	// Stall the receiver until the buffer is full; no word may go missing
	task automatic t_stall;
		i_npf_host.load32(32'h0000_0005);
		pulse(4'h7);
		@(posedge clk) argReady <= 1'h0;
		repeat (6) @(posedge clk);
		argReady <= 1'h1;
		step(1, 32'h0000_0005);
	endtask : t_stall
	// Mid-run reset: registers clear, zero step holds the argument at zero
	task automatic t_reset;
		@(posedge clk) resetn <= 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		wait_n(4);
		chk({31'h0, argValid}, 32'h0000_0001);
		chk(arg, 32'h0000_0000);
		chk({31'h0, pCarry}, 32'h0000_0001);
		step(2, 32'h0000_0000);
	endtask : t_reset
	task automatic printVerdict;
		if (mismatches == 0 && checksDone > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : printVerdict
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		repeat (3) @(posedge clk);
		t_freq;
		t_wrap;
		t_phase;
		t_stall;
		t_reset;
		printVerdict;
	end
	initial begin
		#100000;
		mismatches++;
		printVerdict;
	end
endmodule : tb_top
